//--- src/ptp_defs.svh
`ifndef PTP_DEFS_SVH
`define PTP_DEFS_SVH
`define PTP_CLK_NS 50
`define PTP_CENTI_NS 10000000
`define PTP_CENTI_PER_S 7'h64
`define PTP_S_PER_MIN 6'h3c
`define PTP_PCT_FULL 7'h64
`define PTP_A_CTRL 8'h00
`define PTP_A_PID 8'h04
`define PTP_A_TIME 8'h08
`define PTP_A_SP 8'h0c
`define PTP_A_OFF 8'h10
`define PTP_A_OWN 8'h14
`define PTP_A_DLY 8'h18
`define PTP_A_CFG 8'h1c
`define PTP_A_STAT 8'h20
`define PTP_A_SPR 8'h24
`define PTP_RST_CTRL 32'h0000_0004
`define PTP_RST_PID 32'h0000_0000
`define PTP_RST_TIME 32'h0000_050a
`define PTP_RST_DLY 32'h0000_0000
`define PTP_RST_CFG 32'h0000_042d
`endif

//--- src/ptp_pkg.sv
package ptp_pkg;
    typedef enum logic [1:0] {PTP_STD, PTP_DIFF, PTP_STD_AOUT, PTP_RSVD}
        ptp_mode_t;
    typedef enum logic [1:0] {PTP_SRC_RV, PTP_SRC_ACT, PTP_SRC_SP,
        PTP_SRC_NONE} ptp_src_t;
endpackage

//--- src/ptp_phase_if.sv
interface ptp_phase_if;
    logic tick;
    logic restart;
    logic [7:0] step_len;
    logic [6:0] phase;
    logic done;
    modport ctl (output tick, output restart, output step_len,
        input phase, input done);
    modport tmr (input tick, input restart, input step_len,
        output phase, output done);
endinterface

//--- src/ptp_phase.sv
`include "ptp_defs.svh"
// Percent phase 0..100; one step per step_len centiseconds
module ptp_phase (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    ptp_phase_if.tmr io
);
    logic [7:0] cnt_q;
    logic [6:0] phase_q;
    logic last_step;

    // Zero step length behaves as one to avoid a stuck phase
    assign last_step = (cnt_q + 8'h01 >= io.step_len);
    assign io.phase = phase_q;
    // Wrap flagged on the last step so phase 0 keeps its full length
    assign io.done = io.tick && last_step
        && (phase_q == `PTP_PCT_FULL - 7'h01);

    always_ff @(posedge i_clk)
    begin
        if (i_reset || (i_ce && io.restart))
        begin
            cnt_q <= 8'h00;
            phase_q <= 7'h00;
        end
        else if (i_ce && io.tick && (phase_q != `PTP_PCT_FULL))
        begin
            cnt_q <= last_step ? 8'h00 : cnt_q + 8'h01;
            if (last_step)
                phase_q <= phase_q + 7'h01;
        end
    end
endmodule // ptp_phase

//--- src/ptp_top.sv
// Implementation choices: the placing of the registers and the APB register port.
`include "ptp_defs.svh"
module ptp_top #(
    parameter int CENTI_CYCLES = `PTP_CENTI_NS / `PTP_CLK_NS
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_sensor_fail,
    input wire logic [15:0] i_actual,
    input wire logic i_alarm_cond,
    output logic o_heat_output,
    output logic o_cool_output,
    output logic o_relay_out,
    output logic o_alarm,
    output logic [15:0] o_analog_out
);
    logic [31:0] ctrl_q, pid_q, time_q, sp_q, off_q, own_q, dly_q, cfg_q;
    logic [31:0] stat, spr, rd;
    logic hit, wr;
    ptp_pkg::ptp_mode_t mode;
    ptp_pkg::ptp_src_t src;
    logic signed [7:0] rv_in, rv_eff, cur_q, rv_aout;
    logic signed [8:0] delta;
    logic [7:0] mag_in;
    logic [6:0] heat_pct_q, cool_pct_q;
    logic full_heat_q, full_cool_q, cyc_start;
    logic heat_pid, cool_pid;
    logic [15:0] sp2, sp3;
    logic [17:0] centi_q;
    logic [6:0] cs_q;
    logic [5:0] sec_q;
    logic centi_tick, sec_tick, min_tick;
    logic [8:0] pwr_cnt_q, mut_cnt_q;
    logic [7:0] min_cnt_q;
    logic pwr_done, hold_done, mut_busy_q;
    logic [2:0] req, on_q, en;

    ptp_phase_if cyc ();
    ptp_phase_if vlv ();

    assign mode = ptp_pkg::ptp_mode_t'(ctrl_q[1:0]);
    assign src = ptp_pkg::ptp_src_t'(cfg_q[9:8]);
    assign wr = i_psel && i_penable && i_pwrite && i_ce;

    always_comb
    begin
        hit = 1'b1;
        case (i_paddr)
            `PTP_A_CTRL: rd = ctrl_q;
            `PTP_A_PID: rd = pid_q;
            `PTP_A_TIME: rd = time_q;
            `PTP_A_SP: rd = sp_q;
            `PTP_A_OFF: rd = off_q;
            `PTP_A_OWN: rd = own_q;
            `PTP_A_DLY: rd = dly_q;
            `PTP_A_CFG: rd = cfg_q;
            `PTP_A_STAT: rd = stat;
            `PTP_A_SPR: rd = spr;
            default:
            begin
                rd = 32'h0000_0000;
                hit = 1'b0;
            end
        endcase
    end

    // Read data captured in setup so the slave never waits
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !hit;

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            o_prdata <= 32'h0000_0000;
        else if (i_ce && i_psel && !i_penable)
            o_prdata <= rd;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            ctrl_q <= `PTP_RST_CTRL;
            pid_q <= `PTP_RST_PID;
            time_q <= `PTP_RST_TIME;
            sp_q <= 32'h0000_0000;
            off_q <= 32'h0000_0000;
            own_q <= 32'h0000_0000;
            dly_q <= `PTP_RST_DLY;
            cfg_q <= `PTP_RST_CFG;
        end
        else if (wr)
        begin
            case (i_paddr)
                `PTP_A_CTRL: ctrl_q <= {28'h000_0000, i_pwdata[3:0]};
                `PTP_A_PID: pid_q <= {9'h000, i_pwdata[22:0]};
                `PTP_A_TIME: time_q <= {16'h0000, i_pwdata[15:0]};
                `PTP_A_SP: sp_q <= {16'h0000, i_pwdata[15:0]};
                `PTP_A_OFF: off_q <= i_pwdata;
                `PTP_A_OWN: own_q <= i_pwdata;
                `PTP_A_DLY: dly_q <= {7'h00, i_pwdata[24:16],
                    7'h00, i_pwdata[8:0]};
                `PTP_A_CFG: cfg_q <= {20'h0_0000, i_pwdata[11:0]};
                default: ;
            endcase
        end
    end

    assign stat = {16'h0000, cur_q, 2'b00, hold_done, pwr_done,
        o_alarm, o_relay_out, o_cool_output, o_heat_output};
    assign spr = {sp3, sp2};

    assign sp2 = ctrl_q[2] ? sp_q[15:0] + off_q[15:0] : own_q[15:0];
    assign sp3 = ctrl_q[3] ? sp_q[15:0] + off_q[31:16] : own_q[31:16];

    assign rv_in = i_sensor_fail ? signed'(pid_q[15:8]) : signed'(pid_q[7:0]);
    assign mag_in = rv_in[7] ? 8'(-rv_in) : rv_in;
    assign rv_eff = (mag_in < {1'b0, pid_q[22:16]}) ? 8'sh00 : rv_in;
    assign rv_aout = (mode == ptp_pkg::PTP_STD_AOUT) ? rv_eff : rv_in;

    // Centisecond, second and minute time base
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            centi_q <= 18'h0_0000;
            cs_q <= 7'h00;
            sec_q <= 6'h00;
        end
        else if (i_ce)
        begin
            centi_q <= centi_tick ? 18'h0_0000 : centi_q + 18'h0_0001;
            if (centi_tick)
                cs_q <= sec_tick ? 7'h00 : cs_q + 7'h01;
            if (sec_tick)
                sec_q <= min_tick ? 6'h00 : sec_q + 6'h01;
        end
    end
    assign centi_tick = (centi_q == 18'(CENTI_CYCLES - 1));
    assign sec_tick = centi_tick && (cs_q == `PTP_CENTI_PER_S - 7'h01);
    assign min_tick = sec_tick && (sec_q == `PTP_S_PER_MIN - 6'h01);

    // cycle timer wraps once per period
    assign cyc.tick = centi_tick;
    assign cyc.step_len = time_q[7:0];
    assign cyc.restart = cyc.done;
    assign cyc_start = cyc.done;
    // valve timer restarts with each period
    assign vlv.tick = centi_tick;
    assign vlv.step_len = time_q[15:8];
    assign vlv.restart = cyc_start;

    ptp_phase u_cyc (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .io(cyc)
    );
    ptp_phase u_vlv (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .io(vlv)
    );

    assign delta = 9'(rv_eff) - 9'(cur_q);

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            cur_q <= 8'sh00;
            heat_pct_q <= 7'h00;
            cool_pct_q <= 7'h00;
            full_heat_q <= 1'b0;
            full_cool_q <= 1'b0;
        end
        else if (i_ce && cyc_start)
        begin
            cur_q <= rv_eff;
            full_heat_q <= (mode == ptp_pkg::PTP_DIFF)
                && (rv_eff == 8'sd100);
            full_cool_q <= (mode == ptp_pkg::PTP_DIFF)
                && (rv_eff == -8'sd100);
            case (mode)
                ptp_pkg::PTP_DIFF:
                begin
                    heat_pct_q <= (delta > 9'sd100) ? `PTP_PCT_FULL
                        : (delta > 9'sd0) ? 7'(delta) : 7'h00;
                    cool_pct_q <= (delta < -9'sd100) ? `PTP_PCT_FULL
                        : (delta < 9'sd0) ? 7'(-delta) : 7'h00;
                end
                default:
                begin
                    heat_pct_q <= (rv_eff > 8'sd0) ? 7'(rv_eff) : 7'h00;
                    cool_pct_q <= (rv_eff < 8'sd0) ? 7'(-rv_eff) : 7'h00;
                end
            endcase
        end
    end

    always_comb
    begin
        if (mode == ptp_pkg::PTP_DIFF)
        begin
            heat_pid = full_heat_q || (vlv.phase < heat_pct_q);
            cool_pid = full_cool_q || (vlv.phase < cool_pct_q);
        end
        else
        begin
            heat_pid = cyc.phase < heat_pct_q;
            cool_pid = cyc.phase < cool_pct_q;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            pwr_cnt_q <= 9'h000;
            min_cnt_q <= 8'h00;
        end
        else if (i_ce)
        begin
            if (sec_tick && !pwr_done)
                pwr_cnt_q <= pwr_cnt_q + 9'h001;
            if (min_tick && !hold_done)
                min_cnt_q <= min_cnt_q + 8'h01;
        end
    end
    assign pwr_done = (pwr_cnt_q >= dly_q[8:0]);
    assign hold_done = (min_cnt_q >= cfg_q[7:0]);

    assign req = {i_actual < sp3, i_actual < sp2, heat_pid || cool_pid};

    // one switch-on at a time, lowest circuit first
    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_circ
            if (i == 0)
            begin : g_first
                assign en[i] = req[i] && !on_q[i] && pwr_done && !mut_busy_q;
            end
            else
            begin : g_next
                assign en[i] = req[i] && !on_q[i] && pwr_done
                    && !mut_busy_q && !(|en[i-1:0]);
            end
            always_ff @(posedge i_clk)
            begin
                if (i_reset)
                    on_q[i] <= 1'b0;
                else if (i_ce)
                    on_q[i] <= req[i] && (on_q[i] || en[i]);
            end
        end
    endgenerate

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            mut_busy_q <= 1'b0;
            mut_cnt_q <= 9'h000;
        end
        else if (i_ce)
        begin
            if (|en)
            begin
                mut_busy_q <= (dly_q[24:16] != 9'h000);
                mut_cnt_q <= 9'h000;
            end
            else if (mut_busy_q && sec_tick)
            begin
                mut_cnt_q <= mut_cnt_q + 9'h001;
                if (mut_cnt_q + 9'h001 >= dly_q[24:16])
                    mut_busy_q <= 1'b0;
            end
        end
    end

    // Outputs registered; one clock behind the gating
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_heat_output <= 1'b0;
            o_cool_output <= 1'b0;
            o_relay_out <= 1'b0;
            o_alarm <= 1'b0;
            o_analog_out <= 16'h0000;
        end
        else if (i_ce)
        begin
            // Grant taken early so the first on cycle is not lost
            o_heat_output <= (on_q[0] || en[0]) && heat_pid;
            o_cool_output <= (on_q[0] || en[0]) && cool_pid;
            case (cfg_q[11:10])
                2'h1: o_relay_out <= on_q[0];
                2'h2: o_relay_out <= on_q[1];
                2'h3: o_relay_out <= on_q[2];
                default: o_relay_out <= 1'b0;
            endcase
            o_alarm <= i_alarm_cond && hold_done;
            case (src)
                ptp_pkg::PTP_SRC_RV: o_analog_out <= rv_aout[7]
                    ? 16'h0000 : {8'h00, rv_aout};
                ptp_pkg::PTP_SRC_ACT: o_analog_out <= i_actual[15]
                    ? 16'h0000 : i_actual;
                ptp_pkg::PTP_SRC_SP: o_analog_out <= sp_q[15]
                    ? 16'h0000 : sp_q[15:0];
                default: o_analog_out <= 16'h0000;
            endcase
        end
    end

    pwr_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !pwr_done |=> !o_heat_output && !o_cool_output && !o_relay_out)
        else $error("Relay on during power-on delay");
    alarm_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !hold_done |=> !o_alarm)
        else $error("Alarm during hold-off");
    dead_band_a: assert property (@(posedge i_clk) disable iff (i_reset)
        mag_in < {1'b0, pid_q[22:16]} |-> rv_eff == 8'sh00)
        else $error("Dead band not applied");
    fail_force_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_sensor_fail && pid_q[22:16] == 7'h00 |-> rv_eff == pid_q[15:8])
        else $error("Sensor fail preset missing");
    diff_idle_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && cyc_start && mode == ptp_pkg::PTP_DIFF && rv_eff == cur_q
        |=> heat_pct_q == 7'h00 && cool_pct_q == 7'h00)
        else $error("Differential not idle");
    std_split_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && cyc_start && mode == ptp_pkg::PTP_STD && rv_eff > 8'sd0
        |=> heat_pct_q == $past(rv_eff) && cool_pct_q == 7'h00)
        else $error("Standard split wrong");
    latch_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !cyc_start |=> $stable(cur_q))
        else $error("Value changed mid-period");
    mutual_gap_a: assert property (@(posedge i_clk) disable iff (i_reset)
        mut_busy_q |-> en == 3'b000)
        else $error("Switch-on during mutual delay");
    full_on_a: assert property (@(posedge i_clk) disable iff (i_reset)
        mode == ptp_pkg::PTP_DIFF && full_heat_q |-> heat_pid)
        else $error("Full scale not held");
endmodule // ptp_top

//--- test/ptp_relay_model.sv
module ptp_relay_model (
    input wire logic i_clk,
    input wire logic i_clear,
    input wire logic i_heat,
    input wire logic i_cool,
    input wire logic i_relay,
    output logic [31:0] o_heat_cnt,
    output logic [31:0] o_cool_cnt,
    output logic [31:0] o_relay_cnt,
    output logic [31:0] o_heat_rise
);
    timeunit 1ns;
    timeprecision 1ns;
    logic heat_q;
    // Contacts tally closed time and heat switch-ons; valve end stops are not modelled
    always_ff @(posedge i_clk)
    begin
        heat_q <= i_heat;
        if (i_clear)
        begin
            o_heat_cnt <= 32'h0;
            o_cool_cnt <= 32'h0;
            o_relay_cnt <= 32'h0;
            o_heat_rise <= 32'h0;
        end
        else
        begin
            o_heat_cnt <= o_heat_cnt + 32'(i_heat);
            o_cool_cnt <= o_cool_cnt + 32'(i_cool);
            o_relay_cnt <= o_relay_cnt + 32'(i_relay);
            o_heat_rise <= o_heat_rise + 32'(i_heat & ~heat_q);
        end
    end
endmodule // ptp_relay_model

//--- test/ptp_top_tb_top.sv
`include "ptp_defs.svh"
module ptp_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic sf = 1'b0;
    logic alc = 1'b0;
    logic clr = 1'b0;
    logic [15:0] act = 16'h0;
    logic [31:0] prdata, rd, hc, cc, rc, hr;
    logic pready, pslverr, heat, cool, relay, alarm, er;
    logic [15:0] aout;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] tpid [4] = '{32'h32, 32'hec, 32'h1e_0014, 32'h1e_0028};
    logic [31:0] th [4] = '{32'hc8, 32'h0, 32'h0, 32'ha0};
    logic [31:0] tc [4] = '{32'h0, 32'h50, 32'h0, 32'h0};

    ptp_top #(.CENTI_CYCLES(4)) ptp_top_inst (.i_clk(clk), .i_reset(rst),
        .i_ce(1'b1), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_sensor_fail(sf),
        .i_actual(act), .i_alarm_cond(alc), .o_heat_output(heat),
        .o_cool_output(cool), .o_relay_out(relay), .o_alarm(alarm),
        .o_analog_out(aout));
    ptp_relay_model ptp_relay_model_inst (.i_clk(clk), .i_clear(clr),
        .i_heat(heat), .i_cool(cool), .i_relay(relay), .o_heat_cnt(hc),
        .o_cool_cnt(cc), .o_relay_cnt(rc), .o_heat_rise(hr));

    always #25 clk = ~clk;
    // Whole run needs about 20000 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fail_count++;
            results();
        end
    end

    task results;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // Settle w cycles, then tally n cycles; read at the falling edge
    task meas(input int w, input int n);
        repeat (w) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task s_regs;
        apb(0, `PTP_A_CTRL, 32'h0); chk(rd, `PTP_RST_CTRL);
        apb(0, `PTP_A_TIME, 32'h0); chk(rd, `PTP_RST_TIME);
        apb(0, `PTP_A_CFG, 32'h0); chk(rd, `PTP_RST_CFG);
        apb(0, `PTP_A_DLY, 32'h0); chk(rd, `PTP_RST_DLY);
        apb(0, 8'h28, 32'h0); chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
    endtask

    // Period kept no shorter than valve travel throughout
    task s_power;
        apb(1, `PTP_A_TIME, 32'h101);
        apb(1, `PTP_A_DLY, 32'h1);
        apb(1, `PTP_A_PID, 32'h32);
        alc <= 1'b1;
        meas(0, 340); chk(hc, 32'h0);
        chk({31'h0, alarm}, 32'h0);
    endtask

    task s_std;
        for (int i = 0; i < 4; i++)
        begin
            apb(1, `PTP_A_PID, tpid[i]);
            meas(800, 400); chk(hc, th[i]);
            chk(cc, tc[i]);
            chk(hr, 32'(th[i] != 32'h0));
            chk(rc, th[i] + tc[i]);
        end
        sf <= 1'b1;
        apb(1, `PTP_A_PID, 32'h460a);
        meas(800, 400); chk(hc, 32'h118);
        sf <= 1'b0;
        apb(1, `PTP_A_CFG, 32'h2d);
        apb(1, `PTP_A_PID, 32'h32);
        meas(800, 400); chk(rc, 32'h0);
    endtask

    task s_aout;
        apb(1, `PTP_A_SP, 32'h123);
        apb(1, `PTP_A_CFG, 32'h22d);
        meas(10, 1); chk(32'(aout), 32'h123);
        act <= 16'hff00;
        apb(1, `PTP_A_CFG, 32'h12d);
        meas(10, 1); chk(32'(aout), 32'h0);
        act <= 16'h42;
        meas(10, 1); chk(32'(aout), 32'h42);
        apb(1, `PTP_A_CFG, 32'h2d);
        apb(1, `PTP_A_CTRL, 32'h6);
        apb(1, `PTP_A_PID, 32'h1e_0014);
        meas(800, 1); chk(32'(aout), 32'h0);
        apb(1, `PTP_A_CTRL, 32'h4);
        meas(800, 1); chk(32'(aout != 16'h0), 32'h1);
    endtask

    task s_link;
        apb(1, `PTP_A_SP, 32'h100);
        apb(1, `PTP_A_OFF, 32'h7_0005);
        apb(1, `PTP_A_OWN, 32'h200_0300);
        apb(1, `PTP_A_CTRL, 32'hc);
        apb(0, `PTP_A_SPR, 32'h0); chk(rd, 32'h107_0105);
        apb(1, `PTP_A_CTRL, 32'h0);
        apb(0, `PTP_A_SPR, 32'h0); chk(rd, 32'h200_0300);
    endtask

    // Period twice the travel, so a scaling slip shows as double on-time
    task s_diff;
        apb(1, `PTP_A_CFG, 32'h42d);
        apb(1, `PTP_A_TIME, 32'h102);
        apb(1, `PTP_A_CTRL, 32'h1);
        apb(1, `PTP_A_PID, 32'h14);
        meas(2400, 2000); chk(hc | cc, 32'h0);
        apb(1, `PTP_A_PID, 32'h5);
        meas(0, 2400); chk(cc, 32'h3c);
        chk(hc, 32'h0);
        apb(1, `PTP_A_PID, 32'h64);
        meas(2400, 800); chk(hc, 32'h320);
        apb(1, `PTP_A_CFG, 32'h400);
        meas(10, 1); chk({31'h0, alarm}, 32'h1);
    endtask

    task rst_dut;
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
    endtask

    initial
    begin
        rst_dut();
        s_regs();
        rst_dut();
        s_power();
        s_std();
        s_aout();
        s_link();
        s_diff();
        results();
    end
endmodule // ptp_top_tb_top
